// *** design/usx_pkg.sv ***
// Constants, field positions and state types for the serial transceiver.
// Assumes a 40 MHz ref_clk and a 32-bit AHB-Lite register port.
package usx_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_THR = 8'h14;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int CB_SYNC = 0;
  localparam int CB_WLEN = 1;
  localparam int CB_PEN = 3;
  localparam int CB_PODD = 4;
  localparam int CB_STOP2 = 5;
  localparam int CB_MSB = 6;
  localparam int CB_FLOW = 7;
  localparam int CB_IRDA = 8;
  localparam int CB_RS485 = 9;
  localparam int CB_LIN = 10;
  localparam int CB_BRK = 11;
  localparam logic [1:0] WL_7 = 2'h0;
  localparam logic [1:0] WL_9 = 2'h2;
  localparam logic [11:0] CTRL_RST = 12'h002;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  // ----------------------------------------
  // Status fields, threshold fields
  // ----------------------------------------
  localparam int SB_PAR = 0;
  localparam int SB_FER = 1;
  localparam int SB_OVR = 2;
  localparam int SB_BRK = 3;
  localparam int SB_TXE = 4;
  localparam int SB_RXT = 5;
  localparam int SB_TOUT = 6;
  localparam int SB_W = 7;
  localparam int TB_TOUT = 8;
  localparam logic [3:0] RXTHR_RST = 4'h4;
  localparam logic [7:0] TOUT_RST = 8'h04;
  // ----------------------------------------
  // Character and timing counts
  // ----------------------------------------
  localparam logic [3:0] NBITS_7 = 4'h7;
  localparam logic [3:0] NBITS_8 = 4'h8;
  localparam logic [3:0] NBITS_9 = 4'h9;
  localparam logic [3:0] SHIFT_W = 4'h9;
  localparam logic [3:0] ASYNC_LAST = 4'hF;
  localparam logic [3:0] ASYNC_MID = 4'h7;
  localparam logic [3:0] SYNC_LAST = 4'h7;
  localparam logic [3:0] SYNC_MID = 4'h3;
  localparam logic [3:0] IR_PULSE = 4'h3;
  localparam logic [3:0] IR_HOLD = 4'hF;
  localparam logic [3:0] FIFO_DEPTH = 4'h8;
  localparam logic [3:0] RTS_LEVEL = 4'h7;
  localparam int FIFO_AW = 3;
  localparam int CHAR_W = 9;
  // ----------------------------------------
  // State types
  // ----------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010, TX_PAR = 3'b011, TX_STOP = 3'b100
  } usx_tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010, RX_PAR = 3'b011, RX_STOP = 3'b100,
    RX_WAIT = 3'b101
  } usx_rx_state_t;
endpackage : usx_pkg

// *** design/usx_fifo.sv ***
// Character queue with valid/ready on both sides and a registered read word.
// Assumes both sides run on ref_clk.
`timescale 1ns/1ps
module usx_fifo #(parameter int DW = 9, parameter int AW = 3) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wr_valid,
  input wire logic [DW-1:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [DW-1:0] rd_data,
  output logic [AW:0] count
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  wire do_wr = wr_valid && wr_ready;
  wire do_rd = rd_valid && rd_ready;
  wire [AW-1:0] next_rptr = do_rd ? rptr + 1'b1 : rptr;
  assign wr_ready = count != (AW+1)'(1 << AW);
  assign rd_valid = count != '0;

  always_ff @(posedge ref_clk) begin
    if (do_wr) mem[wptr] <= wr_data;
  end

  // Write-through keeps the head word valid in the cycle count turns nonzero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      rd_data <= '0;
    end else begin
      if (do_wr) wptr <= wptr + 1'b1;
      rptr <= next_rptr;
      if (do_wr && !do_rd) count <= count + 1'b1;
      else if (do_rd && !do_wr) count <= count - 1'b1;
      rd_data <= (do_wr && wptr == next_rptr) ? wr_data : mem[next_rptr];
    end
  end
endmodule : usx_fifo

// *** design/usx_core.sv ***
// Serial transceiver: AHB-Lite registers, baud divider, transmit and receive
// engines with queues, IrDA, RS485, flow control and one level interrupt.
// Assumes rxd and cts_n are asynchronous pins; the bus runs on ref_clk.
`timescale 1ns/1ps
module usx_core
  import usx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rxd,
  input wire logic cts_n,
  output logic txd,
  output logic rts_n,
  output logic sclk,
  output logic de,
  output logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // One wait state so every read word comes out of a register
  logic ap_pend;
  logic ap_wr;
  logic [7:0] ap_addr;
  logic [11:0] ctrl;
  logic [15:0] baud;
  logic [6:0] mask;
  logic [3:0] rx_thr;
  logic [7:0] tout;
  logic [6:0] stat;
  wire take = hsel && htrans[1] && hready && hsize == HSIZE_WORD;
  wire rd_acc = ap_pend && !ap_wr;
  wire wr_acc = ap_pend && ap_wr;
  wire sel_data = ap_addr == ADDR_DATA;
  wire sel_ctrl = ap_addr == ADDR_CTRL;
  wire sel_baud = ap_addr == ADDR_BAUD;
  wire sel_stat = ap_addr == ADDR_STAT;
  wire sel_mask = ap_addr == ADDR_MASK;
  wire sel_thr = ap_addr == ADDR_THR;

  wire sync = ctrl[CB_SYNC];
  wire [1:0] wlen = ctrl[CB_WLEN +: 2];
  wire pen = ctrl[CB_PEN];
  wire podd = ctrl[CB_PODD];
  wire msb = ctrl[CB_MSB];
  wire flow = ctrl[CB_FLOW];
  wire irda = ctrl[CB_IRDA];
  wire lin = ctrl[CB_LIN];
  wire brk = ctrl[CB_BRK];
  wire [3:0] nbits = (wlen == WL_7) ? NBITS_7 : (wlen == WL_9) ? NBITS_9 : NBITS_8;
  wire [3:0] last = sync ? SYNC_LAST : ASYNC_LAST;
  wire [3:0] mid = sync ? SYNC_MID : ASYNC_MID;

  // Reorders the low n bits when the most significant bit travels first
  function automatic logic [8:0] bit_order(input logic [8:0] d, input logic [3:0] n,
                                           input logic m);
    logic [8:0] rev;
    for (int i = 0; i < CHAR_W; i++) rev[i] = d[CHAR_W-1-i];
    return m ? (rev >> (SHIFT_W - n)) : d;
  endfunction : bit_order

  function automatic logic par_of(input logic [8:0] d, input logic [3:0] n, input logic o);
    return (^(d & (9'h1FF >> (SHIFT_W - n)))) ^ o;
  endfunction : par_of

  // ----------------------------------------
  // Pin synchronisers and baud divider
  // ----------------------------------------
  logic rx_m;
  logic rx_s;
  logic cts_m;
  logic cts_s;
  logic [15:0] bcnt;
  wire tick = bcnt == 16'h0000;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_m <= 1'b1;
      rx_s <= 1'b1;
      cts_m <= 1'b1;
      cts_s <= 1'b1;
      bcnt <= 16'h0000;
    end else begin
      rx_m <= rxd;
      rx_s <= rx_m;
      cts_m <= cts_n;
      cts_s <= cts_m;
      bcnt <= tick ? baud : bcnt - 16'h0001;
    end
  end
  a_tick_spacing: assert property (tick && baud != 16'h0000 |=> !tick)
    else $error("baud tick repeated too soon");

  // ----------------------------------------
  // Queues
  // ----------------------------------------
  logic tx_valid;
  logic tx_ready;
  logic [8:0] tx_q;
  logic [3:0] tx_cnt;
  logic rx_push;
  logic rx_room;
  logic rx_valid;
  logic [8:0] rx_q;
  logic [3:0] rx_cnt;
  logic [8:0] rx_word;
  wire rx_pop = rd_acc && sel_data && rx_valid;

  usx_fifo #(.DW(CHAR_W), .AW(FIFO_AW)) u_tx_q (
    .ref_clk(ref_clk), .rst(rst), .wr_valid(wr_acc && sel_data), .wr_data(hwdata[8:0]),
    .wr_ready(), .rd_valid(tx_valid), .rd_ready(tx_ready), .rd_data(tx_q), .count(tx_cnt));
  usx_fifo #(.DW(CHAR_W), .AW(FIFO_AW)) u_rx_q (
    .ref_clk(ref_clk), .rst(rst), .wr_valid(rx_push), .wr_data(rx_word),
    .wr_ready(rx_room), .rd_valid(rx_valid), .rd_ready(rx_pop), .rd_data(rx_q),
    .count(rx_cnt));
  a_rx_depth: assert property (rx_cnt <= FIFO_DEPTH)
    else $error("receive queue beyond eight entries");

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  usx_tx_state_t tx_st;
  logic [3:0] tx_ph;
  logic [3:0] tx_bn;
  logic [8:0] tx_sh;
  logic tx_par;
  logic tx_line;
  wire cts_ok = !flow || !cts_s;
  wire tx_go = tx_st == TX_IDLE && tick && tx_valid && cts_ok && !brk;
  wire tx_end = tick && tx_ph == last;
  wire [3:0] stop_last = ctrl[CB_STOP2] ? 4'h1 : 4'h0;
  assign tx_ready = tx_go;

  always_comb begin
    case (tx_st)
      TX_START: tx_line = 1'b0;
      TX_DATA: tx_line = tx_sh[0];
      TX_PAR: tx_line = tx_par;
      default: tx_line = 1'b1;
    endcase
  end
  // Break overrides the frame; LIN break fields are sent this way
  wire line_out = tx_line && !brk;
  wire ir_out = !line_out && tx_ph < IR_PULSE;
  wire next_txd = irda ? ir_out : line_out;
  wire next_sclk = sync && tx_st == TX_DATA && tx_ph > mid;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_st <= TX_IDLE;
      tx_ph <= 4'h0;
      tx_bn <= 4'h0;
      tx_sh <= 9'h000;
      tx_par <= 1'b0;
    end else if (tx_go) begin
      tx_sh <= bit_order(tx_q, nbits, msb);
      tx_par <= par_of(tx_q, nbits, podd);
      tx_ph <= 4'h0;
      tx_st <= TX_START;
    end else if (tick && tx_st != TX_IDLE) begin
      tx_ph <= tx_end ? 4'h0 : tx_ph + 4'h1;
      if (tx_end) begin
        case (tx_st)
          TX_START: begin
            tx_bn <= 4'h0;
            tx_st <= TX_DATA;
          end
          TX_DATA: begin
            tx_sh <= tx_sh >> 1;
            tx_bn <= (tx_bn == nbits - 4'h1) ? 4'h0 : tx_bn + 4'h1;
            if (tx_bn == nbits - 4'h1) tx_st <= pen ? TX_PAR : TX_STOP;
          end
          TX_PAR: tx_st <= TX_STOP;
          TX_STOP: begin
            tx_bn <= tx_bn + 4'h1;
            if (tx_bn == stop_last) tx_st <= TX_IDLE;
          end
          default: tx_st <= TX_IDLE;
        endcase
      end
    end
  end
  a_cts_hold: assert property (flow && cts_s && tx_st == TX_IDLE |=> tx_st == TX_IDLE)
    else $error("transmit started while clear-to-send is off");
  a_stop_line: assert property (tx_st == TX_STOP && !brk |-> line_out)
    else $error("stop bit not high");
  a_sclk_async: assert property (!sync |=> !sclk)
    else $error("bit clock toggles in asynchronous mode");

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  usx_rx_state_t rx_st;
  logic [3:0] ir_hold;
  logic [3:0] rx_ph;
  logic [3:0] rx_bn;
  logic [8:0] rx_sh;
  logic rx_bit;
  logic rx_pbit;
  logic rx_zero;
  logic [7:0] idle_bits;
  // A short IrDA pulse is stretched so the mid-bit sample still sees it
  wire rx_line = irda ? !(rx_s || ir_hold != 4'h0) : rx_s;
  wire rx_end = tick && rx_ph == last;
  wire [8:0] rx_data = bit_order(rx_sh >> (SHIFT_W - nbits), nbits, msb);
  wire stop_smp = rx_st == RX_STOP && tick && rx_ph == mid;
  wire brk_ev = stop_smp && rx_zero && !rx_line;
  wire fer_ev = stop_smp && !rx_line;
  wire par_ev = stop_smp && pen && rx_pbit != par_of(rx_data, nbits, podd);
  wire rx_char = stop_smp && !(lin && brk_ev);
  wire ovr_ev = rx_char && !rx_room;
  wire idle_wrap = rx_st == RX_IDLE && rx_end;
  wire tout_ev = idle_wrap && rx_valid && tout != 8'h00 && idle_bits + 8'h01 == tout;
  assign rx_push = rx_char && rx_room;
  assign rx_word = rx_data;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ir_hold <= 4'h0;
      idle_bits <= 8'h00;
    end else begin
      if (rx_s) ir_hold <= IR_HOLD;
      else if (tick && ir_hold != 4'h0) ir_hold <= ir_hold - 4'h1;
      if (rx_push || !rx_valid || rx_st != RX_IDLE) idle_bits <= 8'h00;
      else if (idle_wrap && idle_bits != 8'hFF) idle_bits <= idle_bits + 8'h01;
    end
  end

  // Runs beside the transmitter with its own phase and shift state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_st <= RX_IDLE;
      rx_ph <= 4'h0;
      rx_bn <= 4'h0;
      rx_sh <= 9'h000;
      rx_bit <= 1'b1;
      rx_pbit <= 1'b0;
      rx_zero <= 1'b0;
    end else if (tick) begin
      rx_ph <= rx_end ? 4'h0 : rx_ph + 4'h1;
      if (rx_ph == mid) rx_bit <= rx_line;
      case (rx_st)
        RX_IDLE: begin
          if (!rx_line) begin
            rx_ph <= 4'h0;
            rx_st <= RX_START;
          end
        end
        RX_START: begin
          if (rx_ph == mid && rx_line) rx_st <= RX_IDLE;
          else if (rx_end) begin
            rx_bn <= 4'h0;
            rx_zero <= 1'b1;
            rx_st <= RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_end) begin
            rx_sh <= {rx_bit, rx_sh[8:1]};
            rx_zero <= rx_zero && !rx_bit;
            rx_bn <= rx_bn + 4'h1;
            if (rx_bn == nbits - 4'h1) rx_st <= pen ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: begin
          if (rx_end) begin
            rx_pbit <= rx_bit;
            rx_zero <= rx_zero && !rx_bit;
            rx_st <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_ph == mid) rx_st <= rx_line ? RX_IDLE : RX_WAIT;
        end
        RX_WAIT: begin
          if (rx_line) rx_st <= RX_IDLE;
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Status, interrupt and registers
  // ----------------------------------------
  // Events win over a read-clear in the same cycle
  wire txe_ev = tx_go && tx_cnt == 4'h1;
  wire rxt_ev = rx_thr != 4'h0 && rx_cnt >= rx_thr;
  wire [6:0] ev = {tout_ev, rxt_ev, txe_ev, brk_ev, ovr_ev, fer_ev, par_ev};
  wire [6:0] next_stat = (stat & ~{SB_W{rd_acc && sel_stat}}) | ev;
  wire [31:0] stat_word = {20'h00000, rx_st != RX_IDLE, tx_st != TX_IDLE, rx_valid,
                           !tx_valid, 1'b0, stat};
  wire [31:0] rd_mux = sel_data ? {23'h000000, rx_q} :
                       sel_ctrl ? {20'h00000, ctrl} :
                       sel_baud ? {16'h0000, baud} :
                       sel_stat ? stat_word :
                       sel_mask ? {25'h0000000, mask} :
                       sel_thr ? {16'h0000, tout, 4'h0, rx_thr} : 32'h00000000;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ap_pend <= 1'b0;
      ap_wr <= 1'b0;
      ap_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      ap_pend <= take;
      hreadyout <= !take;
      if (take) begin
        ap_wr <= hwrite;
        ap_addr <= haddr[7:0];
      end
      if (rd_acc) hrdata <= rd_mux;
    end
  end
  a_bus_wait: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not after one wait state");

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RST;
      baud <= BAUD_RST;
      mask <= 7'h00;
      rx_thr <= RXTHR_RST;
      tout <= TOUT_RST;
    end else if (wr_acc) begin
      if (sel_ctrl) ctrl <= hwdata[11:0];
      if (sel_baud) baud <= hwdata[15:0];
      if (sel_mask) mask <= hwdata[6:0];
      if (sel_thr) begin
        rx_thr <= hwdata[3:0];
        tout <= hwdata[TB_TOUT +: 8];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat <= 7'h00;
      irq <= 1'b0;
      txd <= 1'b1;
      sclk <= 1'b0;
      de <= 1'b0;
      rts_n <= 1'b0;
    end else begin
      stat <= next_stat;
      irq <= |(next_stat & mask);
      txd <= next_txd;
      sclk <= next_sclk;
      de <= ctrl[CB_RS485] && tx_st != TX_IDLE;
      rts_n <= flow && rx_cnt >= RTS_LEVEL;
    end
  end
  a_ovr_flag: assert property (ovr_ev |=> stat[SB_OVR] && rx_cnt == FIFO_DEPTH)
    else $error("overrun not flagged");
  a_brk_flag: assert property (brk_ev |=> stat[SB_BRK] && stat[SB_FER])
    else $error("break not flagged");
  a_irq_cause: assert property ($rose(irq) |-> (stat & mask) != 7'h00)
    else $error("interrupt without unmasked status");
  a_de_window: assert property (ctrl[CB_RS485] && tx_st == TX_DATA |=> de)
    else $error("driver enable low while sending");
endmodule : usx_core

// *** verif/usx_rmt.sv ***
// Remote serial party: captures characters from txd and sends characters on rxd.
// Assumes the bench sets its format fields to match the block's control word.
`timescale 1ns/1ps
module usx_rmt (
  input wire logic ref_clk,
  input wire logic txd,
  output logic rxd,
  output logic cts_n
);
  // ----
  // Receive and send sides
  // ----
  int bit_clks = 16;
  int nbits = 8;
  logic par_en = 1'b0;
  logic par_odd = 1'b0;
  logic msb = 1'b0;
  logic [8:0] got = 9'h000;
  logic got_par = 1'b0;
  int n_got = 0;
  initial begin
    rxd = 1'b1;
    cts_n = 1'b0;
  end
  // Mid-bit sampling; the far end must use the same format
  always begin
    @(negedge txd);
    repeat (bit_clks / 2) @(posedge ref_clk);
    got = 9'h000;
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_clks) @(posedge ref_clk);
      got[msb ? nbits - 1 - i : i] = txd;
    end
    if (par_en) begin
      repeat (bit_clks) @(posedge ref_clk);
      got_par = txd;
    end
    repeat (bit_clks) @(posedge ref_clk);
    n_got++;
  end
  // Frame out; faults only when the bench asks for them
  task automatic send(input logic [8:0] d, input logic bad_par, input logic bad_stop);
    logic p;
    p = par_odd ^ bad_par;
    @(posedge ref_clk);
    rxd <= 1'b0;
    repeat (bit_clks) @(posedge ref_clk);
    for (int i = 0; i < nbits; i++) begin
      rxd <= d[msb ? nbits - 1 - i : i];
      p = p ^ d[i];
      repeat (bit_clks) @(posedge ref_clk);
    end
    if (par_en) begin
      rxd <= p;
      repeat (bit_clks) @(posedge ref_clk);
    end
    rxd <= ~bad_stop;
    repeat (bit_clks) @(posedge ref_clk);
    rxd <= 1'b1;
  endtask : send
  // Remote half of the handshake
  task automatic set_cts(input logic v);
    cts_n <= v;
  endtask : set_cts
endmodule : usx_rmt

// *** verif/usx_core_tb_top.sv ***
// Self-checking bench: bus tasks, five scenario tasks grouping related checks, remote serial model.
// Takes any number of wait states per bus transfer; assumes BAUD left at zero.
`timescale 1ns/1ps
module usx_core_tb_top
  import usx_pkg::*;
;
  // ----
  // Harness
  // ----
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, r;
  logic hreadyout, hresp, rxd, cts_n, txd, rts_n, sclk, de, irq;
  int n_fail = 0;
  int n_compared = 0;
  int n_sclk = 0;
  int n_irp = 0;
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge sclk) n_sclk++;
  always @(posedge txd) n_irp++;
  usx_core usx_core_inst (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .cts_n(cts_n),
    .txd(txd), .rts_n(rts_n), .sclk(sclk), .de(de), .irq(irq));
  usx_rmt usx_rmt_inst (.ref_clk(ref_clk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Waits on hready without assuming a latency
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  // Reformat only between frames, so no stop count or enable changes mid-character
  task automatic set_fmt(input logic [11:0] c);
    bus(1'b0, ADDR_STAT, 32'h0);
    for (int t = 0; t < 100 && r[11:10] !== 2'b00; t++) bus(1'b0, ADDR_STAT, 32'h0);
    usx_rmt_inst.nbits = 7 + int'(c[CB_WLEN +: 2]);
    usx_rmt_inst.bit_clks = c[CB_SYNC] ? 8 : 16;
    usx_rmt_inst.par_en = c[CB_PEN];
    usx_rmt_inst.par_odd = c[CB_PODD];
    usx_rmt_inst.msb = c[CB_MSB];
    bus(1'b1, ADDR_CTRL, {20'h00000, c});
  endtask : set_fmt
  task automatic wait_got(input int n);
    for (int t = 0; t < 3000 && usx_rmt_inst.n_got < n; t++) @(posedge ref_clk);
    chk("char count", n, usx_rmt_inst.n_got);
  endtask : wait_got
  task automatic drain();
    for (int t = 0; t < 10; t++) begin
      bus(1'b0, ADDR_STAT, 32'h0);
      if (r[9] === 1'b1) bus(1'b0, ADDR_DATA, 32'h0);
    end
  endtask : drain
  task automatic tx_one(input logic [8:0] d);
    int n;
    n = usx_rmt_inst.n_got;
    bus(1'b1, ADDR_DATA, {23'h0, d});
    wait_got(n + 1);
    chk("tx char", {23'h0, d}, {23'h0, usx_rmt_inst.got});
  endtask : tx_one
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    chk("irq idle", 32'h0, {31'h0, irq});
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'h0000_0002, r);
    chk("hresp okay", 32'h0, {31'h0, hresp});
    bus(1'b0, ADDR_THR, 32'h0);
    chk("thr reset", 32'h0000_0404, r);
    bus(1'b0, ADDR_STAT, 32'h0);
    chk("status reset", 32'h0000_0100, r);
    bus(1'b1, 8'h18, 32'hFFFF_FFFF);
    bus(1'b0, 8'h18, 32'h0);
    chk("unmapped", 32'h0, r);
  endtask : t_reset
  task automatic t_formats();
    logic [11:0] cfg [4] = '{12'h002, 12'h008, 12'h07C, 12'h042};
    logic [8:0] dat [4] = '{9'h0A5, 9'h05B, 9'h1C3, 9'h031};
    logic [8:0] m;
    logic p;
    for (int k = 0; k < 4; k++) begin
      set_fmt(cfg[k]);
      m = 9'h1FF >> (9 - usx_rmt_inst.nbits);
      p = ^(dat[k] & m) ^ cfg[k][CB_PODD];
      fork
        usx_rmt_inst.send(~dat[k], 1'b0, 1'b0);
      join_none
      tx_one(dat[k] & m);
      if (cfg[k][CB_PEN]) chk("tx parity", {31'h0, p}, {31'h0, usx_rmt_inst.got_par});
      for (int t = 0; t < 200 && r[9] !== 1'b1; t++) bus(1'b0, ADDR_STAT, 32'h0);
      bus(1'b0, ADDR_DATA, 32'h0);
      chk("rx char", {23'h0, ~dat[k] & m}, r);
    end
  endtask : t_formats
  task automatic err_case(input logic [8:0] d, input logic bp, input logic bs,
                          input logic [3:0] e);
    usx_rmt_inst.send(d, bp, bs);
    repeat (4) @(posedge ref_clk);
    chk("irq masked", {31'h0, e[SB_PAR]}, {31'h0, irq});
    bus(1'b0, ADDR_STAT, 32'h0);
    chk("error flags", {28'h0, e}, r & 32'h0000_000F);
    drain();
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask : err_case
  task automatic t_errors();
    set_fmt(12'h08A);
    bus(1'b1, ADDR_MASK, 32'h0000_0001);
    drain();
    err_case(9'h03C, 1'b1, 1'b0, 4'h1);
    err_case(9'h03C, 1'b0, 1'b1, 4'h2);
    err_case(9'h000, 1'b0, 1'b1, 4'hA);
    for (int i = 0; i < 9; i++) usx_rmt_inst.send(9'(i), 1'b0, 1'b0);
    repeat (4) @(posedge ref_clk);
    bus(1'b0, ADDR_STAT, 32'h0);
    chk("overrun", 32'h4, r & 32'h0000_0004);
    chk("rts full", 32'h1, {31'h0, rts_n});
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ADDR_DATA, 32'h0);
      chk("rx order", i, r & 32'h0000_01FF);
    end
    bus(1'b0, ADDR_STAT, 32'h0);
    chk("rx empty", 32'h0, r & 32'h0000_0200);
  endtask : t_errors
  task automatic t_misc();
    int n;
    set_fmt(12'h002);
    bus(1'b1, ADDR_MASK, 32'h0000_0010);
    drain();
    tx_one(9'h055);
    chk("irq tx empty", 32'h1, {31'h0, irq});
    set_fmt(12'h082);
    usx_rmt_inst.set_cts(1'b1);
    n = usx_rmt_inst.n_got;
    bus(1'b1, ADDR_DATA, 32'h0000_0033);
    repeat (400) @(posedge ref_clk);
    chk("held by cts", n, usx_rmt_inst.n_got);
    chk("rts", 32'h0, {31'h0, rts_n});
    usx_rmt_inst.set_cts(1'b0);
    wait_got(n + 1);
    set_fmt(12'h202);
    chk("de idle", 32'h0, {31'h0, de});
    fork
      tx_one(9'h05A);
      begin
        wait (txd === 1'b0);
        repeat (4) @(posedge ref_clk);
        chk("de on", 32'h1, {31'h0, de});
      end
    join
    repeat (24) @(posedge ref_clk);
    chk("de off", 32'h0, {31'h0, de});
    set_fmt(12'h003);
    n = n_sclk;
    tx_one(9'h096);
    chk("sclk pulses", 32'h8, n_sclk - n);
  endtask : t_misc
  task automatic t_more();
    int n;
    set_fmt(12'h002);
    bus(1'b1, ADDR_THR, 32'h0000_0402);
    drain();
    usx_rmt_inst.send(9'h011, 1'b0, 1'b0);
    repeat (100) @(posedge ref_clk);
    bus(1'b0, ADDR_STAT, 32'h0);
    chk("time-out only", 32'h40, r & 32'h0000_0060);
    usx_rmt_inst.send(9'h022, 1'b0, 1'b0);
    repeat (4) @(posedge ref_clk);
    bus(1'b0, ADDR_STAT, 32'h0);
    chk("threshold", 32'h20, r & 32'h0000_0060);
    drain();
    set_fmt(12'h402);
    usx_rmt_inst.send(9'h000, 1'b0, 1'b1);
    repeat (4) @(posedge ref_clk);
    bus(1'b0, ADDR_STAT, 32'h0);
    chk("lin break", 32'h00A, r & 32'h0000_020F);
    set_fmt(12'h802);
    repeat (8) @(posedge ref_clk);
    chk("break out", 32'h0, {31'h0, txd});
    // The remote reads the break as a frame; let it finish before the next low edge
    set_fmt(12'h002);
    repeat (200) @(posedge ref_clk);
    n = n_irp;
    set_fmt(12'h102);
    bus(1'b1, ADDR_DATA, 32'h0000_000F);
    repeat (200) @(posedge ref_clk);
    chk("ir pulses", 32'h5, n_irp - n);
  endtask : t_more
  task automatic stop_test();
    if (n_fail == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_formats();
    t_errors();
    t_misc();
    t_more();
    stop_test();
  end
  // Whole run needs well under this; a hang ends here
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    stop_test();
  end
endmodule : usx_core_tb_top
